// [hw/gec_map.svh]
// register offsets, field positions, reset values and timing counts of the counter block
`ifndef GEC_MAP_SVH
`define GEC_MAP_SVH
`define GEC_OFF_CTRL      12'h000
`define GEC_OFF_CFG       12'h004
`define GEC_OFF_DELAY     12'h008
`define GEC_OFF_WIDTH     12'h00c
`define GEC_OFF_NPULSE    12'h010
`define GEC_OFF_COUNT     12'h014
`define GEC_OFF_STATUS    12'h018
`define GEC_CTRL_START    0
`define GEC_CTRL_STOP     1
`define GEC_CTRL_PSTART   2
`define GEC_CTRL_PSTOP    3
`define GEC_CFG_EDGE      0
`define GEC_CFG_CASCADE   1
`define GEC_CFG_TBSEL     2
`define GEC_CFG_POL       3
`define GEC_CFG_TRAIN     4
`define GEC_CFG_GATE_LSB  8
`define GEC_CFG_RST       32'h0000_0000
`define GEC_DELAY_RST     16'h0000
`define GEC_NPULSE_RST    16'h0000
`define GEC_MIN_PHASE     16'h0003
`define GEC_TB_DIV        8'h03
`endif

// [hw/gec_pkg.sv]
// types shared by the counter and pulse generator block
package gec_pkg;
    typedef enum logic [2:0] {
        GEC_GATE_NONE  = 3'b000,
        GEC_GATE_HIGH  = 3'b001,
        GEC_GATE_LOW   = 3'b010,
        GEC_GATE_RISE  = 3'b011,
        GEC_GATE_FALL  = 3'b100,
        GEC_GATE_RRISE = 3'b101,
        GEC_GATE_RFALL = 3'b110
    } gec_gate_t;
    typedef enum logic [1:0] {
        GEC_PG_IDLE  = 2'b00,
        GEC_PG_ARM   = 2'b01,
        GEC_PG_DELAY = 2'b10,
        GEC_PG_PULSE = 2'b11
    } gec_pg_state_t;
    typedef struct packed {
        gec_gate_t gate;
        logic      train;
        logic      pol;
        logic      tbsel;
        logic      cascade;
        logic      edge_fall;
    } gec_cfg_t;
endpackage : gec_pkg

// [hw/gec_counter.sv]
// event counter and delayed pulse / pulse train generator with apb slave
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "gec_map.svh"
// Functional notes
// - count one per selected source transition
// - edge setting: 0 rising, 1 falling
// - cascaded count is high<<16 plus low
// - start loads config, restart reinitialises
// - stop halts counters
// - pulse: delay level, pulse level, back
// - zero delay with internal timebase: three
// - zero width with internal timebase: three
// - timebase select: 0 internal, 1 external
// - gate mode 0 ignores gate
// - modes 1/2 run while gate high/low
// - modes 3/4 one pulse on first edge
// - modes 5/6 retrigger on every edge
// - polarity 0 low then high, 1 inverted
// - train repeats delay then pulse
// - pulse count zero means endless train
// - period at least two timebase cycles
module gec_counter
    import gec_pkg::*;
(
    input  wire logic        pclk,             // bus and core clock, 40 MHz
    input  wire logic        presetn,          // asynchronous reset, active low
    input  wire logic        psel,             // apb select
    input  wire logic        penable,          // apb access phase
    input  wire logic        pwrite,           // apb direction
    input  wire logic [11:0] paddr,            // apb byte address
    input  wire logic [31:0] pwdata,           // apb write data
    output logic      [31:0] prdata,           // apb read data
    output logic             pready,           // apb ready
    output logic             pslverr,          // apb error on unmapped address
    input  wire logic        event_source_pin, // counted event input
    input  wire logic        gate_input_pin,   // gate input
    input  wire logic        ext_tb_pin,       // external timebase input
    output logic             pulse_output_pin  // pulse output
);
    // synchronisers: stage one feeds stage two only
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] prev_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            prev_reg  <= 3'h0;
        end else begin
            sync1_reg <= {ext_tb_pin, gate_input_pin, event_source_pin};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end
    wire src_s  = sync2_reg[0];
    wire gate_s = sync2_reg[1];
    wire rise_v [3];
    wire fall_v [3];
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_edge
            assign rise_v[gi] = sync2_reg[gi] & ~prev_reg[gi];
            assign fall_v[gi] = ~sync2_reg[gi] & prev_reg[gi];
        end
    endgenerate

    // configuration and apb
    gec_cfg_t    cfg_reg;
    logic [15:0] delay_reg;
    logic [15:0] width_reg;
    logic [15:0] npulse_reg;
    logic [15:0] cnt_lo_reg;
    logic [15:0] cnt_hi_reg;
    logic        run_reg;
    logic [7:0]  div_reg;
    wire wr_en = psel & penable & pwrite;
    wire rd_en = psel & penable & ~pwrite;
    wire hit_ctrl   = (paddr == `GEC_OFF_CTRL);
    wire hit_cfg    = (paddr == `GEC_OFF_CFG);
    wire hit_delay  = (paddr == `GEC_OFF_DELAY);
    wire hit_width  = (paddr == `GEC_OFF_WIDTH);
    wire hit_npulse = (paddr == `GEC_OFF_NPULSE);
    wire hit_count  = (paddr == `GEC_OFF_COUNT);
    wire hit_status = (paddr == `GEC_OFF_STATUS);
    wire mapped = hit_ctrl | hit_cfg | hit_delay | hit_width | hit_npulse | hit_count | hit_status;
    wire ctl_start  = wr_en & hit_ctrl & pwdata[`GEC_CTRL_START];
    wire ctl_stop   = wr_en & hit_ctrl & pwdata[`GEC_CTRL_STOP];
    wire ctl_pstart = wr_en & hit_ctrl & pwdata[`GEC_CTRL_PSTART];
    wire ctl_pstop  = wr_en & hit_ctrl & pwdata[`GEC_CTRL_PSTOP];
    wire [31:0] cfg_word = {20'h0_0000, 1'b0, cfg_reg.gate, 3'h0, cfg_reg.train, cfg_reg.pol,
                            cfg_reg.tbsel, cfg_reg.cascade, cfg_reg.edge_fall};
    gec_pg_state_t pg_state_reg;
    wire pg_busy = (pg_state_reg != GEC_PG_IDLE);

    wire [31:0] count_word = cfg_reg.cascade ? {cnt_hi_reg, cnt_lo_reg} : {16'h0000, cnt_lo_reg};
    wire [31:0] rd_mux = hit_cfg    ? cfg_word :
                         hit_delay  ? {16'h0000, delay_reg} :
                         hit_width  ? {16'h0000, width_reg} :
                         hit_npulse ? {16'h0000, npulse_reg} :
                         hit_count  ? count_word :
                         hit_status ? {29'h0000_0000, pulse_output_pin, pg_busy, run_reg} :
                         32'h0000_0000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : prdata;
        end
    end
    // writes take effect on the completing access edge
    wire wr_go = wr_en & pready;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg    <= gec_cfg_t'(8'(`GEC_CFG_RST));
            delay_reg  <= `GEC_DELAY_RST;
            width_reg  <= `GEC_DELAY_RST;
            npulse_reg <= `GEC_NPULSE_RST;
        end else if (wr_go) begin
            if (hit_cfg) begin
                cfg_reg <= '{gate: gec_gate_t'(pwdata[`GEC_CFG_GATE_LSB +: 3]),
                             train: pwdata[`GEC_CFG_TRAIN], pol: pwdata[`GEC_CFG_POL],
                             tbsel: pwdata[`GEC_CFG_TBSEL], cascade: pwdata[`GEC_CFG_CASCADE],
                             edge_fall: pwdata[`GEC_CFG_EDGE]};
            end else if (hit_delay) begin
                delay_reg <= pwdata[15:0];
            end else if (hit_width) begin
                width_reg <= pwdata[15:0];
            end else if (hit_npulse) begin
                npulse_reg <= pwdata[15:0];
            end
        end
    end

    // timebase tick
    wire int_tick = (div_reg == 8'h00);
    wire tb_tick = cfg_reg.tbsel ? rise_v[2] : int_tick;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= int_tick ? `GEC_TB_DIV : div_reg - 8'h01;
        end
    end

    // gate level qualifier shared by counter and generator
    function automatic logic gate_ok(input gec_gate_t m, input logic g);
        case (m)
            GEC_GATE_HIGH: gate_ok = g;
            GEC_GATE_LOW:  gate_ok = ~g;
            default:       gate_ok = 1'b1;
        endcase
    endfunction
    // mode 0 and edge modes do not gate the count level
    wire cnt_gate = gate_ok(cfg_reg.gate, gate_s);
    wire src_evt = cfg_reg.edge_fall ? fall_v[0] : rise_v[0];

    // event counter
    wire cnt_adv = run_reg & cnt_gate & src_evt & ~ctl_stop & ~ctl_start;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg    <= 1'b0;
            cnt_lo_reg <= 16'h0000;
            cnt_hi_reg <= 16'h0000;
        end else if (ctl_start & wr_go) begin
            // start or restart clears and runs
            run_reg    <= 1'b1;
            cnt_lo_reg <= 16'h0000;
            cnt_hi_reg <= 16'h0000;
        end else if (ctl_stop & wr_go) begin
            run_reg <= 1'b0;
        end else if (cnt_adv) begin
            cnt_lo_reg <= cnt_lo_reg + 16'h0001;
            if (cfg_reg.cascade && cnt_lo_reg == 16'hffff) begin
                cnt_hi_reg <= cnt_hi_reg + 16'h0001;
            end
        end
    end

    // pulse generator
    // zero delay promoted to minimum
    wire [15:0] delay_eff = (delay_reg == 16'h0000) ? `GEC_MIN_PHASE : delay_reg;
    wire [15:0] width_eff = (width_reg == 16'h0000) ? `GEC_MIN_PHASE : width_reg;
    wire gate_edge_r = rise_v[1];
    wire gate_edge_f = fall_v[1];
    wire trig = (cfg_reg.gate == GEC_GATE_RISE || cfg_reg.gate == GEC_GATE_RRISE) ? gate_edge_r :
                (cfg_reg.gate == GEC_GATE_FALL || cfg_reg.gate == GEC_GATE_RFALL) ? gate_edge_f :
                1'b0;
    wire edge_mode = (cfg_reg.gate >= GEC_GATE_RISE);
    wire retrig    = (cfg_reg.gate == GEC_GATE_RRISE) || (cfg_reg.gate == GEC_GATE_RFALL);
    wire pg_gate   = gate_ok(cfg_reg.gate, gate_s);
    logic [15:0] phase_cnt_reg;
    logic [15:0] pulses_reg;
    gec_pg_state_t pg_next;
    logic [15:0]   phase_next;
    wire phase_done = tb_tick & pg_gate & (phase_cnt_reg == 16'h0001);
    // pulses_reg counts finished pulses, so the one now ending is pulses_reg + 1
    wire last_pulse = ~cfg_reg.train |
                      ((npulse_reg != 16'h0000) & ((pulses_reg + 16'h0001) == npulse_reg));
    always_comb begin
        pg_next    = pg_state_reg;
        phase_next = phase_cnt_reg;
        case (pg_state_reg)
            GEC_PG_IDLE: begin
            end
            GEC_PG_ARM: begin
                if (trig) begin
                    pg_next    = GEC_PG_DELAY;
                    phase_next = delay_eff;
                end
            end
            GEC_PG_DELAY: begin
                if (phase_done) begin
                    pg_next    = GEC_PG_PULSE;
                    phase_next = width_eff;
                end else if (tb_tick & pg_gate) begin
                    phase_next = phase_cnt_reg - 16'h0001;
                end
            end
            default: begin
                if (phase_done) begin
                    if (!last_pulse) begin
                        pg_next    = GEC_PG_DELAY;
                        phase_next = delay_eff;
                    end else begin
                        pg_next = retrig ? GEC_PG_ARM : GEC_PG_IDLE;
                    end
                end else if (tb_tick & pg_gate) begin
                    phase_next = phase_cnt_reg - 16'h0001;
                end
            end
        endcase
        if (retrig && trig && pg_state_reg != GEC_PG_IDLE) begin
            pg_next    = GEC_PG_DELAY;
            phase_next = delay_eff;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pg_state_reg  <= GEC_PG_IDLE;
            phase_cnt_reg <= 16'h0000;
            pulses_reg    <= 16'h0000;
        end else if (ctl_pstop & wr_go) begin
            pg_state_reg <= GEC_PG_IDLE;
        end else if (ctl_pstart & wr_go) begin
            // load and start, or arm for edges
            pg_state_reg  <= edge_mode ? GEC_PG_ARM : GEC_PG_DELAY;
            phase_cnt_reg <= delay_eff;
            pulses_reg    <= 16'h0000;
        end else begin
            pg_state_reg  <= pg_next;
            phase_cnt_reg <= phase_next;
            if (pg_state_reg == GEC_PG_PULSE && phase_done) begin
                pulses_reg <= pulses_reg + 16'h0001;
            end else if (pg_next == GEC_PG_DELAY && pg_state_reg == GEC_PG_ARM) begin
                pulses_reg <= 16'h0000;
            end
        end
    end
    // output level from phase and polarity
    // a start or stop write overrides the state walk, so the pin follows it too
    wire pulse_ph_d = ~(wr_go & (ctl_pstart | ctl_pstop)) & (pg_next == GEC_PG_PULSE);
    wire out_next   = pulse_ph_d ^ cfg_reg.pol;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_output_pin <= 1'b0;
        end else begin
            pulse_output_pin <= out_next;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_edge_counts: assert property (cnt_adv
        |=> cnt_lo_reg == $past(cnt_lo_reg) + 16'h0001)
        else $error("count did not advance on edge");
    a_edge_select: assert property (run_reg && cfg_reg.edge_fall && rise_v[0] && !fall_v[0]
        && !(wr_go && hit_ctrl) |=> $stable(cnt_lo_reg))
        else $error("counted the wrong edge");
    a_cascade_word: assert property (psel && !penable && !pwrite && hit_count
        && cfg_reg.cascade |=> prdata[31:16] == $past(cnt_hi_reg)
        && prdata[15:0] == $past(cnt_lo_reg))
        else $error("cascade word wrong");
    a_start_clears: assert property (ctl_start && wr_go
        |=> run_reg && cnt_lo_reg == 16'h0000)
        else $error("start did not clear counter");
    a_stop_halts: assert property (!run_reg && !(wr_go && ctl_start)
        |=> $stable(cnt_lo_reg))
        else $error("stopped counter advanced");
    a_pulse_level: assert property (pg_state_reg == GEC_PG_PULSE
        |-> pulse_output_pin != $past(cfg_reg.pol))
        else $error("pulse phase level wrong");
    a_idle_level: assert property (pg_state_reg == GEC_PG_IDLE
        && $past(pg_state_reg) == GEC_PG_IDLE |-> pulse_output_pin == $past(cfg_reg.pol))
        else $error("idle level wrong");
    a_width_min: assert property (pg_state_reg == GEC_PG_PULSE
        && $past(pg_state_reg) == GEC_PG_DELAY && $past(width_reg) == 16'h0000
        && $past(cfg_reg.tbsel) == 1'b0 |-> phase_cnt_reg == `GEC_MIN_PHASE)
        else $error("minimum width not applied");
    a_delay_min: assert property (delay_reg == 16'h0000 && !cfg_reg.tbsel
        && ctl_pstart && wr_go && !ctl_pstop |=> phase_cnt_reg == `GEC_MIN_PHASE)
        else $error("minimum delay not applied");
    a_carry_high: assert property (cnt_adv && cfg_reg.cascade && cnt_lo_reg == 16'hffff
        && !(wr_go && hit_ctrl) |=> cnt_hi_reg == $past(cnt_hi_reg) + 16'h0001)
        else $error("cascade carry lost");
    c_count_edge: cover property (cnt_adv);
    c_pulse_done: cover property (pg_state_reg == GEC_PG_PULSE ##1 pg_state_reg == GEC_PG_IDLE);
    c_train_loop: cover property (pg_state_reg == GEC_PG_PULSE ##1 pg_state_reg == GEC_PG_DELAY);
    c_retrigger:  cover property (retrig && trig && pg_state_reg == GEC_PG_PULSE);
endmodule : gec_counter
`default_nettype wire

// [sim/gec_ext_sig.sv]
// partner model: external source, gate and timebase signals
`timescale 1ns/100ps
`default_nettype none
module gec_ext_sig (
    input  wire logic pclk,     // bench clock
    input  wire logic src_lvl,  // requested event source level
    input  wire logic gate_lvl, // requested gate level
    input  wire logic tb_en,    // lets the external timebase run
    output logic      src_o,    // drives the event source pin
    output logic      gate_o,   // drives the gate pin
    output logic      tb_o      // external timebase
);
    logic [2:0] tb_cnt;
    // pins follow the requested levels one pclk later, held as long as requested
    always @(posedge pclk) begin
        src_o  <= src_lvl;
        gate_o <= gate_lvl;
    end
    // timebase period ten pclk, still unless enabled
    always @(posedge pclk) begin
        if (!tb_en) begin
            tb_cnt <= 3'h0;
            tb_o   <= 1'b0;
        end else begin
            tb_cnt <= (tb_cnt == 3'h4) ? 3'h0 : tb_cnt + 3'h1;
            if (tb_cnt == 3'h4) tb_o <= ~tb_o;
        end
    end
endmodule : gec_ext_sig
`default_nettype wire

// [sim/tb_gated_event_counter_pulse_gen.sv]
// testbench for the counter and pulse generator block
`timescale 1ns/100ps
`default_nettype none
`include "gec_map.svh"
module tb_gated_event_counter_pulse_gen import gec_pkg::*; ();
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, src, gate, tb, pout, e, idl, src_lvl, gate_lvl, tb_en;
    int          err_count, checks, n;

    gec_counter i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_source_pin(src), .gate_input_pin(gate),
        .ext_tb_pin(tb), .pulse_output_pin(pout));
    gec_ext_sig i_ext (.pclk(pclk), .src_lvl(src_lvl), .gate_lvl(gate_lvl), .tb_en(tb_en),
        .src_o(src), .gate_o(gate), .tb_o(tb));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rv, output logic ev);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rv;
        logic        ev;
        apb(1'b1, a, d, rv, ev);
    endtask : wr
    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x);
        logic [31:0] rv;
        logic        ev;
        apb(1'b0, a, 32'h0, rv, ev);
        chk(nm, x, rv);
        chk({nm, " slverr"}, 32'h0, {31'h0, ev});
    endtask : rd
    task automatic pw(input logic act, output int w);
        int t;
        w = 0;
        t = 0;
        while (pout !== act && t < 3000) begin
            @(posedge pclk);
            t++;
        end
        while (pout === act && w < 3000) begin
            @(posedge pclk);
            w++;
        end
    endtask : pw
    task automatic rises(input int c, output int k);
        logic p;
        k = 0;
        p = pout;
        repeat (c) begin
            @(posedge pclk);
            if (pout === 1'b1 && p === 1'b0) k++;
            p = pout;
        end
    endtask : rises
    // hold each source level three ticks
    task automatic set_src(input logic v);
        @(posedge pclk);
        src_lvl <= v;
        repeat (12) @(posedge pclk);
    endtask : set_src
    // hold each gate level three ticks
    task automatic set_gate(input logic v);
        @(posedge pclk);
        gate_lvl <= v;
        repeat (12) @(posedge pclk);
    endtask : set_gate
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    initial begin
        repeat (30000) @(posedge pclk);
        err_count++;
        $display("MISMATCH watchdog expected finish seen hang");
        end_of_test();
    end

    initial begin
        err_count = 0;
        checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        src_lvl = 1'b0;
        gate_lvl = 1'b0;
        tb_en = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd("cfg reset", `GEC_OFF_CFG, `GEC_CFG_RST);
        rd("npulse reset", `GEC_OFF_NPULSE, 32'h0);
        chk("idle output", 32'h0, {31'h0, pout});
        apb(1'b0, 12'h0fc, 32'h0, r, e);
        chk("unmapped slverr", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        for (int ed = 0; ed < 2; ed++) begin
            wr(`GEC_OFF_CFG, 32'(ed));
            wr(`GEC_OFF_CTRL, 32'h1);
            rd("status running", `GEC_OFF_STATUS, 32'h1);
            set_src(1'b1);
            set_src(1'b0);
            set_src(1'b1);
            rd("edge count", `GEC_OFF_COUNT, ed ? 32'h1 : 32'h2);
            wr(`GEC_OFF_CTRL, 32'h2);
            set_src(1'b0);
            set_src(1'b1);
            rd("stopped count", `GEC_OFF_COUNT, ed ? 32'h1 : 32'h2);
            set_src(1'b0);
        end
        wr(`GEC_OFF_CFG, 32'h2);
        wr(`GEC_OFF_CTRL, 32'h1);
        repeat (2) begin
            set_src(1'b1);
            set_src(1'b0);
        end
        rd("cascade count", `GEC_OFF_COUNT, 32'h2);
        for (int m = 1; m < 3; m++) begin
            wr(`GEC_OFF_CFG, 32'(m) << 8);
            wr(`GEC_OFF_CTRL, 32'h1);
            set_src(1'b1);
            set_src(1'b0);
            rd("gated count", `GEC_OFF_COUNT, 32'(m == 2));
        end
        for (int p = 0; p < 2; p++) begin
            wr(`GEC_OFF_CFG, 32'(p) << 3);
            wr(`GEC_OFF_DELAY, p ? 32'h2 : 32'h0);
            wr(`GEC_OFF_WIDTH, p ? 32'h5 : 32'h0);
            wr(`GEC_OFF_CTRL, 32'h4);
            pw(!p, n);
            chk("pulse width", p ? 32'd20 : 32'd12, 32'(n));
            repeat (50) @(posedge pclk);
            chk("rest level", 32'(p), {31'h0, pout});
        end
        wr(`GEC_OFF_CFG, 32'h10);
        wr(`GEC_OFF_DELAY, 32'h0);
        wr(`GEC_OFF_WIDTH, 32'h0);
        wr(`GEC_OFF_NPULSE, 32'h3);
        wr(`GEC_OFF_CTRL, 32'h4);
        rises(400, n);
        chk("train pulses", 32'h3, 32'(n));
        apb(1'b0, `GEC_OFF_STATUS, 32'h0, r, e);
        chk("train done busy", 32'h0, r & 32'h2);
        wr(`GEC_OFF_NPULSE, 32'h0);
        wr(`GEC_OFF_CTRL, 32'h4);
        rises(400, n);
        chk("endless train", 32'h1, 32'(n >= 16));
        wr(`GEC_OFF_CTRL, 32'h8);
        repeat (60) @(posedge pclk);
        apb(1'b0, `GEC_OFF_STATUS, 32'h0, r, e);
        chk("stopped busy", 32'h0, r & 32'h2);
        for (int m = 3; m < 7; m++) begin
            idl = (m == 4 || m == 6);
            set_gate(idl);
            wr(`GEC_OFF_CFG, 32'(m) << 8);
            wr(`GEC_OFF_CTRL, 32'h4);
            rises(100, n);
            chk("armed no pulse", 32'h0, 32'(n));
            fork
                set_gate(!idl);
                rises(300, n);
            join
            chk("first edge pulse", 32'h1, 32'(n));
            set_gate(idl);
            fork
                set_gate(!idl);
                rises(300, n);
            join
            chk("second edge pulse", 32'(m > 4), 32'(n));
            wr(`GEC_OFF_CTRL, 32'h8);
        end
        // reset in mid-run while a counter and an inverted train are active
        wr(`GEC_OFF_CFG, 32'h18);
        wr(`GEC_OFF_CTRL, 32'h5);
        repeat (30) @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk("reset output", 32'h0, {31'h0, pout});
        rd("reset cfg", `GEC_OFF_CFG, `GEC_CFG_RST);
        rd("reset status", `GEC_OFF_STATUS, 32'h0);
        wr(`GEC_OFF_CFG, 32'h4);
        wr(`GEC_OFF_DELAY, 32'h1);
        wr(`GEC_OFF_WIDTH, 32'h4);
        tb_en <= 1'b1;
        wr(`GEC_OFF_CTRL, 32'h4);
        pw(1'b1, n);
        chk("ext width", 32'h1, 32'(n > 36 && n < 44));
        end_of_test();
    end
endmodule : tb_gated_event_counter_pulse_gen
`default_nettype wire
